// ---- rtl/lrpm_cfg.svh ----
// Purpose: Constants for the reset and power-mode controller
// Assumes: AHB-Lite word registers, 40 MHz hclk
// Notes: Function list below
// Function
// - External reset initializes link and transceiver
// - Enable bit one holds link in init
// - Soft init keeps control register contents
// - Enable bit one powers transceiver down
// - Standby gates clocks, oscillator keeps running
// - Standby with halt select stops oscillator
// - In card mode, card power-down drives standby bit
`ifndef LRPM_CFG_SVH
`define LRPM_CFG_SVH
`define LRPM_ADDR_LINK_A 8'h00
`define LRPM_ADDR_LINK_B 8'h04
`define LRPM_ADDR_BUF_E 8'h08
`define LRPM_ADDR_CARD_B 8'h0c
`define LRPM_ADDR_STATUS 8'h10
`define LRPM_ADDR_MCAST 8'h14
`define LRPM_BIT_DLE 7
`define LRPM_BIT_STANDBY_N_BIT 5
`define LRPM_BIT_OSCSEL 4
`define LRPM_BIT_PWRDN 2
`define LRPM_RST_LINK_A 8'h80
`define LRPM_RST_LINK_B 8'h20
`define LRPM_RST_BYTE 8'h00
`define LRPM_CLK_MHZ 40
`define LRPM_OSC_START_US 100
`define LRPM_HOST_WAIT_US 200
`endif

// ---- rtl/lrpm_pkg.sv ----
// Purpose: Types for the reset and power-mode controller
// Assumes: Nothing
// Notes: Constants sit in lrpm_cfg.svh
package lrpm_pkg;
  typedef enum logic [2:0] {LRPM_RUN, LRPM_STANDBY, LRPM_SHUTDOWN, LRPM_OSC_WAIT,
    LRPM_CLK_ON} lrpm_pwr_t;
endpackage

// ---- rtl/lrpm_pwr_if.sv ----
// Purpose: Carrier between top and power sequencer
// Assumes: Same clock on both sides
// Notes: Plain request and status signals
`timescale 1ns/10ps
`default_nettype none
interface lrpm_pwr_if;
  logic standby_n_bit; // Zero requests low power
  logic osc_halt_sel; // One picks shutdown
  logic clk_run; // Internal clocks enabled
  logic osc_run; // Oscillator running
  logic waking; // Wake sequence in progress
  modport top (output standby_n_bit, output osc_halt_sel,
    input clk_run, input osc_run, input waking);
  modport seq (input standby_n_bit, input osc_halt_sel,
    output clk_run, output osc_run, output waking);
endinterface
`default_nettype wire

// ---- rtl/lrpm_pwr_seq.sv ----
// Purpose: Standby and shutdown sequencing
// Assumes: Oscillator start time fixed by a count
// Notes: Clock enable freezes state
`timescale 1ns/10ps
`default_nettype none
`include "lrpm_cfg.svh"
module lrpm_pwr_seq
  import lrpm_pkg::*;
#(
  parameter int OSC_START_CYC = (`LRPM_OSC_START_US * `LRPM_CLK_MHZ)
)(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // Carrier
  lrpm_pwr_if.seq pw
);
  lrpm_pwr_t state_ff; // Power state
  logic [15:0] osc_cnt_ff; // Oscillator settle counter

  // Power state sequencing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= LRPM_RUN;
      osc_cnt_ff <= 16'h0000;
    end
    else if (clk_en)
    begin
      unique case (state_ff)
        LRPM_RUN:
        begin
          // Low power requested
          if (!pw.standby_n_bit)
            state_ff <= pw.osc_halt_sel ? LRPM_SHUTDOWN : LRPM_STANDBY;
        end
        LRPM_STANDBY:
        begin
          if (pw.standby_n_bit)
            state_ff <= LRPM_CLK_ON;
          else if (pw.osc_halt_sel)
            state_ff <= LRPM_SHUTDOWN;
        end
        LRPM_SHUTDOWN:
        begin
          osc_cnt_ff <= 16'h0000;
          if (pw.standby_n_bit)
            state_ff <= LRPM_OSC_WAIT;
        end
        LRPM_OSC_WAIT:
        begin
          // Oscillator must settle before clocks return
          if (osc_cnt_ff == 16'(OSC_START_CYC - 1))
            state_ff <= LRPM_CLK_ON;
          else
            osc_cnt_ff <= osc_cnt_ff + 16'h0001;
        end
        LRPM_CLK_ON:
          state_ff <= LRPM_RUN;
      endcase
    end
  end

  // Decoded outputs
  always_comb
  begin
    pw.osc_run = (state_ff != LRPM_SHUTDOWN);
    pw.clk_run = (state_ff == LRPM_RUN) || (state_ff == LRPM_CLK_ON);
    pw.waking = (state_ff == LRPM_OSC_WAIT) || (state_ff == LRPM_CLK_ON);
  end

  AST_OSC_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == LRPM_SHUTDOWN) |-> !pw.osc_run && !pw.clk_run)
    else $error("oscillator runs in shutdown");
  AST_STANDBY_N_BIT_OSC: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == LRPM_STANDBY) |-> pw.osc_run && !pw.clk_run)
    else $error("standby state wrong");
  AST_OSC_FIRST: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(state_ff) == LRPM_SHUTDOWN && state_ff != LRPM_SHUTDOWN) |-> !pw.clk_run)
    else $error("clocks before oscillator settled");
endmodule
`default_nettype wire

// ---- rtl/lrpm_top.sv ----
// Purpose: Reset and power-mode control block on AHB-Lite
// Assumes: Single word transfers, zero wait states
// Notes: Pins pass two flops before use
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "lrpm_cfg.svh"
module lrpm_top
  import lrpm_pkg::*;
#(
  parameter int OSC_START_CYC = (`LRPM_OSC_START_US * `LRPM_CLK_MHZ)
)(
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // Mode pin
  input wire logic card_mode_pin,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Power and reset controls
  output logic link_init,
  output logic xcvr_reset,
  output logic xcvr_power_down,
  output logic clk_gate_en,
  output logic osc_enable
);
  lrpm_pwr_if pw();
  logic [7:0] link_control_reg_a_ff; // Holds data_link_enable
  logic [7:0] link_control_reg_b_ff; // Holds standby_n_bit
  logic [7:0] buffer_mgmt_reg_e_ff; // Holds oscillator_halt_select
  logic [7:0] card_config_reg_b_ff; // Holds card_power_down
  logic [7:0] multicast_filter_ff; // Sample preserved register
  logic [1:0] card_sync_ff; // Mode pin synchroniser
  logic por_ff; // Marks first cycles after hard reset
  logic wr_pend_ff; // Write data phase pending
  logic [7:0] wr_addr_ff; // Latched write address
  logic [7:0] rd_addr_ff; // Latched read address
  logic rd_pend_ff; // Read data phase pending
  logic link_init_ff, xcvr_reset_ff, xcvr_pd_ff, clk_gate_ff, osc_en_ff;
  logic [31:0] hrdata_ff;
  logic addr_ok;
  logic card_mode;

  // Address phase qualifier
  assign addr_ok = hsel && hready && htrans[1];
  assign card_mode = card_sync_ff[1];
  assign pw.standby_n_bit = link_control_reg_b_ff[`LRPM_BIT_STANDBY_N_BIT];
  assign pw.osc_halt_sel = buffer_mgmt_reg_e_ff[`LRPM_BIT_OSCSEL];

  // Byte readback for a word address
  function automatic logic [7:0] reg_pick(input logic [7:0] a, input logic [7:0] ra,
    input logic [7:0] rb, input logic [7:0] re, input logic [7:0] cb,
    input logic [7:0] mf, input logic [7:0] st);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `LRPM_ADDR_LINK_A: v = ra;
      `LRPM_ADDR_LINK_B: v = rb;
      `LRPM_ADDR_BUF_E: v = re;
      `LRPM_ADDR_CARD_B: v = cb;
      `LRPM_ADDR_MCAST: v = mf;
      `LRPM_ADDR_STATUS: v = st;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Mode pin synchroniser
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      card_sync_ff <= 2'h0;
    else if (clk_en)
      card_sync_ff <= {card_sync_ff[0], card_mode_pin};
  end

  // Bus phase tracking, zero wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rd_addr_ff <= 8'h00;
    end
    else if (clk_en)
    begin
      wr_pend_ff <= addr_ok && hwrite;
      rd_pend_ff <= addr_ok && !hwrite;
      if (addr_ok)
      begin
        wr_addr_ff <= haddr;
        rd_addr_ff <= haddr;
      end
    end
  end

  // Register writes; hard reset is the only clearing path
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link_control_reg_a_ff <= `LRPM_RST_LINK_A;
      buffer_mgmt_reg_e_ff <= `LRPM_RST_BYTE;
      card_config_reg_b_ff <= `LRPM_RST_BYTE;
      multicast_filter_ff <= `LRPM_RST_BYTE;
    end
    else if (clk_en && wr_pend_ff)
    begin
      // Soft init never clears these, only writes change them
      unique case (wr_addr_ff)
        `LRPM_ADDR_LINK_A: link_control_reg_a_ff <= hwdata[7:0];
        `LRPM_ADDR_BUF_E: buffer_mgmt_reg_e_ff <= hwdata[7:0];
        `LRPM_ADDR_CARD_B: card_config_reg_b_ff <= hwdata[7:0];
        `LRPM_ADDR_MCAST: multicast_filter_ff <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Standby bit: card mode follows power-down, else host writes it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      link_control_reg_b_ff <= `LRPM_RST_LINK_B;
    else if (clk_en)
    begin
      if (card_mode)
      begin
        // Host writes to the standby bit are ignored here
        link_control_reg_b_ff[`LRPM_BIT_STANDBY_N_BIT] <=
          !card_config_reg_b_ff[`LRPM_BIT_PWRDN];
        if (wr_pend_ff && wr_addr_ff == `LRPM_ADDR_LINK_B)
        begin
          link_control_reg_b_ff[7:6] <= hwdata[7:6];
          link_control_reg_b_ff[4:0] <= hwdata[4:0];
        end
      end
      else if (wr_pend_ff && wr_addr_ff == `LRPM_ADDR_LINK_B)
        link_control_reg_b_ff <= hwdata[7:0];
    end
  end

  // Hard reset marker for transceiver reset pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      por_ff <= 1'b1;
    else if (clk_en)
      por_ff <= 1'b0;
  end

  // Control outputs, all registered
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link_init_ff <= 1'b1;
      xcvr_reset_ff <= 1'b1;
      xcvr_pd_ff <= 1'b1;
      clk_gate_ff <= 1'b1;
      osc_en_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      link_init_ff <= link_control_reg_a_ff[`LRPM_BIT_DLE] || pw.waking;
      xcvr_reset_ff <= por_ff;
      xcvr_pd_ff <= link_control_reg_a_ff[`LRPM_BIT_DLE];
      clk_gate_ff <= pw.clk_run;
      osc_en_ff <= pw.osc_run;
    end
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= 32'h0000_0000;
    else if (clk_en && addr_ok && !hwrite)
      hrdata_ff <= {24'h00_0000, reg_pick(haddr, link_control_reg_a_ff,
        link_control_reg_b_ff, buffer_mgmt_reg_e_ff, card_config_reg_b_ff,
        multicast_filter_ff, {3'h0, card_mode, pw.waking, pw.osc_run,
        pw.clk_run, link_init_ff})};
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign link_init = link_init_ff;
  assign xcvr_reset = xcvr_reset_ff;
  assign xcvr_power_down = xcvr_pd_ff;
  assign clk_gate_en = clk_gate_ff;
  assign osc_enable = osc_en_ff;

  lrpm_pwr_seq #(.OSC_START_CYC(OSC_START_CYC)) u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .pw(pw.seq)
  );

  AST_PD_FOLLOW: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && card_mode |=> link_control_reg_b_ff[`LRPM_BIT_STANDBY_N_BIT] ==
    !$past(card_config_reg_b_ff[`LRPM_BIT_PWRDN]))
    else $error("standby bit does not follow power-down");
  AST_XCVR_PD: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && link_control_reg_a_ff[`LRPM_BIT_DLE] |=> xcvr_power_down)
    else $error("transceiver not powered down");
  AST_LINK_INIT: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && link_control_reg_a_ff[`LRPM_BIT_DLE] |=> link_init)
    else $error("link not held in init");
  AST_KEEP_MCAST: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_pend_ff |=> $stable(multicast_filter_ff))
    else $error("filter changed without write");
  AST_XCVR_RST: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !por_ff |=> !xcvr_reset)
    else $error("transceiver reset stuck");
  // A frozen cycle must not move link_init, clk_gate_en or osc_enable
  AST_FREEZE: assert property (@(posedge hclk) disable iff (!hresetn)
    !clk_en |=> $stable(link_init) && $stable(clk_gate_en) && $stable(osc_enable))
    else $error("outputs moved while clock enable low");
  // Soft init holds the buffer settings as well
  AST_KEEP_BUF: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_pend_ff |=> $stable(buffer_mgmt_reg_e_ff))
    else $error("buffer setting changed without write");
endmodule
`default_nettype wire

// ---- test/lrpm_host_model.sv ----
// Purpose: Host model issuing AHB-Lite single word transfers
// Assumes: One slave, hready looped back from hreadyout
// Notes: Released address and data show inverted values
`timescale 1ns/10ps
`default_nettype none
module lrpm_host_model #(
  parameter int WAIT_CYC = 8000
)(
  // Clock and answer
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Request
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Idle bus from time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One word transfer, waits on hready in both phases
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    haddr <= ~a;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    // Stale data must not look valid
    hwdata <= ~d;
  endtask

  // Host pause in the wake sequence; registers may be set meanwhile
  task automatic host_wait();
    repeat (WAIT_CYC) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ---- test/tb_lan_reset_power_mode_ctrl.sv ----
// Purpose: Self-checking bench for the power-mode controller
// Assumes: Oscillator start count shortened to 16
// Notes: Fixed seed random register values
`timescale 1ns/10ps
`default_nettype none
`include "lrpm_cfg.svh"
module tb_lan_reset_power_mode_ctrl;
  logic hclk, hresetn, card_mode_pin, hsel, hwrite, hready, hresp, clk_en;
  logic link_init, xcvr_reset, xcvr_power_down, clk_gate_en, osc_enable;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r, vm, ve;
  int err_count, checks_done, k;

  lrpm_top #(.OSC_START_CYC(16)) i_lrpm_top (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .card_mode_pin(card_mode_pin), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .link_init(link_init), .xcvr_reset(xcvr_reset), .xcvr_power_down(xcvr_power_down),
    .clk_gate_en(clk_gate_en), .osc_enable(osc_enable));
  lrpm_host_model i_lrpm_host_model (.hclk(hclk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  // 40 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // Only the low byte of a word is kept
  function automatic logic [31:0] exp_rd(input logic [31:0] w);
    return {24'h0, w[7:0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_lrpm_host_model.xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a);
    i_lrpm_host_model.xfer(1'b0, a, 32'h0, r);
  endtask

  // Let edge updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, well past the expected run
  initial
  begin
    #(25 * 40000);
    err_count++;
    finish_test();
  end

  initial
  begin
    hresetn = 1'b0;
    card_mode_pin = 1'b0;
    clk_en = 1'b1;
    err_count = 0;
    checks_done = 0;
    r = $urandom(32'h8847);
    cyc(16);
    chk({link_init, xcvr_reset, xcvr_power_down, clk_gate_en, osc_enable}, 5'h1f);
    @(posedge hclk);
    hresetn <= 1'b1;
    cyc(3);
    chk({link_init, xcvr_reset, xcvr_power_down}, 3'b101);
    rd(`LRPM_ADDR_LINK_A);
    chk(r, 32'h80);
    rd(`LRPM_ADDR_LINK_B);
    chk(r, 32'h20);
    chk({hready, hresp}, 2'b10);
    // Soft init must keep stored settings
    for (k = 0; k < 4; k++)
    begin
      vm = $urandom;
      ve = $urandom & 32'hffff_ffef;
      wr(`LRPM_ADDR_MCAST, vm);
      wr(`LRPM_ADDR_BUF_E, ve);
      wr(`LRPM_ADDR_LINK_A, 32'h0);
      cyc(2);
      chk({link_init, xcvr_power_down}, 2'b00);
      wr(`LRPM_ADDR_LINK_A, 32'h80);
      cyc(2);
      chk({link_init, xcvr_power_down, xcvr_reset}, 3'b110);
      rd(`LRPM_ADDR_MCAST);
      chk(r, exp_rd(vm));
      rd(`LRPM_ADDR_BUF_E);
      chk(r, exp_rd(ve));
    end
    rd(8'h18);
    chk(r, 32'h0);
    // Standby, oscillator stays on
    wr(`LRPM_ADDR_BUF_E, 32'h0);
    wr(`LRPM_ADDR_LINK_B, 32'h0);
    cyc(6);
    chk({clk_gate_en, osc_enable}, 2'b01);
    wr(`LRPM_ADDR_LINK_B, 32'h20);
    cyc(6);
    chk({clk_gate_en, osc_enable}, 2'b11);
    // Shutdown, then oscillator first on wake
    wr(`LRPM_ADDR_BUF_E, 32'h10);
    wr(`LRPM_ADDR_LINK_B, 32'h0);
    cyc(6);
    chk({clk_gate_en, osc_enable}, 2'b00);
    wr(`LRPM_ADDR_LINK_B, 32'h20);
    cyc(4);
    chk({clk_gate_en, osc_enable, link_init}, 3'b011);
    for (k = 0; k < 200 && clk_gate_en !== 1'b1; k++)
      cyc(1);
    chk(clk_gate_en, 1'b1);
    i_lrpm_host_model.host_wait();
    // Frozen enable: a standby request must not be taken
    clk_en <= 1'b0;
    wr(`LRPM_ADDR_LINK_B, 32'h0);
    cyc(6);
    chk({clk_gate_en, osc_enable}, 2'b11);
    clk_en <= 1'b1;
    rd(`LRPM_ADDR_LINK_B);
    chk(r, 32'h20);
    // Card mode: standby bit only via power-down
    card_mode_pin <= 1'b1;
    wr(`LRPM_ADDR_BUF_E, 32'h0);
    wr(`LRPM_ADDR_CARD_B, 32'h04);
    rd(`LRPM_ADDR_LINK_B);
    chk(r & 32'h20, 32'h0);
    // A direct standby write in card mode is ignored
    wr(`LRPM_ADDR_LINK_B, 32'h20);
    rd(`LRPM_ADDR_LINK_B);
    chk(r & 32'h20, 32'h0);
    cyc(6);
    chk({clk_gate_en, osc_enable}, 2'b01);
    wr(`LRPM_ADDR_CARD_B, 32'h0);
    rd(`LRPM_ADDR_LINK_B);
    chk(r & 32'h20, 32'h20);
    rd(`LRPM_ADDR_STATUS);
    chk(r & 32'h10, 32'h10);
    // Reset in mid-run
    wr(`LRPM_ADDR_LINK_A, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b0;
    cyc(2);
    chk({xcvr_reset, link_init, xcvr_power_down}, 3'b111);
    hresetn <= 1'b1;
    cyc(1);
    chk(xcvr_reset, 1'b1);
    cyc(1);
    chk(xcvr_reset, 1'b0);
    cyc(1);
    rd(`LRPM_ADDR_LINK_A);
    chk(r, 32'h80);
    finish_test();
  end
endmodule
`default_nettype wire
